/* File: hw/chain_edge_detect.v */
// rising edge detector after a two-stage synchroniser
`timescale 1ns/100ps
module chain_edge_detect (
   input wire clk_i,
   input wire rst_n_i,
   input wire async_i,
   output reg rise_o
);
   reg meta_ff;
   reg sync_ff;
   reg last_ff;

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
         rise_o <= sync_ff & ~last_ff;
      end
   end
endmodule

/* File: hw/chain_trigger_monitor.v */
// chain trigger monitor top: edge margin and rearm supervision with axi4-lite registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "chain_monitor_consts.vh"

// What this block does
// - enlarged capture of secondaries overlaps the primary's captured data
// - unit supervises its chain segment continuously while enabled
// - secondary flags edge margin when chain edge lands near reference edge
// - primary flags rearm overrun on a trigger inside its rearm period
// - primary rearm period is fixed at two reference clock cycles
// - both conditions are single-bit sticky flags held until read
// - reading chain status clears both sticky flags
// - margin warning never blocks forwarding of the chain signal
// - edge past the window into next cycle gives no warning
// - margin window shrinks as sampling rate rises
module chain_trigger_monitor (
   input wire CLOCK_I,
   input wire RESET_N_I,
   input wire REF_CLK_I,
   input wire CHAIN_IN_I,
   input wire TRIGGER_I,
   input wire [`WIN_WIDTH-1:0] RATE_WINDOW_I,
   output reg CHAIN_OUT_O,
   output reg CAPTURE_START_O,
   output reg SLIP_O,
   output reg IRQ_O,
   input wire [3:0] S_AXI_AWADDR_I,
   input wire S_AXI_AWVALID_I,
   output reg S_AXI_AWREADY_O,
   input wire [31:0] S_AXI_WDATA_I,
   input wire [3:0] S_AXI_WSTRB_I,
   input wire S_AXI_WVALID_I,
   output reg S_AXI_WREADY_O,
   output reg [1:0] S_AXI_BRESP_O,
   output reg S_AXI_BVALID_O,
   input wire S_AXI_BREADY_I,
   input wire [3:0] S_AXI_ARADDR_I,
   input wire S_AXI_ARVALID_I,
   output reg S_AXI_ARREADY_O,
   output reg [31:0] S_AXI_RDATA_O,
   output reg [1:0] S_AXI_RRESP_O,
   output reg S_AXI_RVALID_O,
   input wire S_AXI_RREADY_I
);
   ////////////////////////////////////////////////////////////////////////////
   // registers and synchronised inputs
   reg [31:0] control_ff;
   reg [`IRQ_BITS-1:0] irq_status_ff;
   reg [`IRQ_BITS-1:0] irq_mask_ff;
   reg [`WIN_WIDTH-1:0] win_meta_ff;
   reg [`WIN_WIDTH-1:0] win_sync_ff;
   reg [`REF_CNT_WIDTH-1:0] since_ref_ff;
   reg [1:0] rearm_ff;
   reg [3:0] aw_addr_ff;
   reg aw_have_ff;
   reg [31:0] w_data_ff;
   reg [3:0] w_strb_ff;
   reg w_have_ff;
   wire ref_rise;
   wire chain_rise;
   wire trig_rise;
   wire margin_flag;
   wire rearm_flag;
   wire is_primary;
   wire enabled;
   wire [`WIN_WIDTH-1:0] window;
   wire margin_hit;
   wire rearm_hit;
   wire status_read;
   wire do_write;
   wire [`IRQ_BITS-1:0] events;
   wire [`IRQ_BITS-1:0] irq_clear;
   reg [31:0] rd_data;
   reg rd_ok;

   assign is_primary = control_ff[`CTRL_PRIMARY];
   assign enabled = control_ff[`CTRL_ENABLE];
   assign window = (control_ff[`CTRL_WIN_HI:`CTRL_WIN_LO] != {`WIN_WIDTH{1'b0}}) ?
                   control_ff[`CTRL_WIN_HI:`CTRL_WIN_LO] : win_sync_ff;

   chain_edge_detect u_ref (
      .clk_i(CLOCK_I),
      .rst_n_i(RESET_N_I),
      .async_i(REF_CLK_I),
      .rise_o(ref_rise)
   );

   chain_edge_detect u_chain (
      .clk_i(CLOCK_I),
      .rst_n_i(RESET_N_I),
      .async_i(CHAIN_IN_I),
      .rise_o(chain_rise)
   );

   chain_edge_detect u_trig (
      .clk_i(CLOCK_I),
      .rst_n_i(RESET_N_I),
      .async_i(TRIGGER_I),
      .rise_o(trig_rise)
   );

   ////////////////////////////////////////////////////////////////////////////
   // window width from the sampling rate setting, shorter at higher rates
   always @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         win_meta_ff <= {`WIN_WIDTH{1'b0}};
         win_sync_ff <= {`WIN_WIDTH{1'b0}};
      end else begin
         win_meta_ff <= RATE_WINDOW_I;
         win_sync_ff <= win_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // distance of the chain edge from the last reference edge
   always @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         since_ref_ff <= {`REF_CNT_WIDTH{1'b1}};
      end else if (ref_rise) begin
         since_ref_ff <= {`REF_CNT_WIDTH{1'b0}};
      end else if (since_ref_ff != {`REF_CNT_WIDTH{1'b1}}) begin
         since_ref_ff <= since_ref_ff + 1'b1;
      end
   end

   // edge at or just after the reference edge; later edges fall in the next cycle
   assign margin_hit = enabled & ~is_primary & chain_rise &
                       (ref_rise | (since_ref_ff < {{(`REF_CNT_WIDTH-`WIN_WIDTH){1'b0}}, window}));

   ////////////////////////////////////////////////////////////////////////////
   // primary propagation stage with fixed rearm of two reference cycles
   assign rearm_hit = enabled & is_primary & trig_rise & (rearm_ff != 2'h0);

   always @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         rearm_ff <= 2'h0;
      end else if (enabled & is_primary & trig_rise & (rearm_ff == 2'h0)) begin
         rearm_ff <= `REARM_REF_CYCLES;
      end else if (ref_rise & (rearm_ff != 2'h0)) begin
         rearm_ff <= rearm_ff - 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // chain forwarding and capture start, never gated by the warning
   always @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         CHAIN_OUT_O <= 1'b0;
         CAPTURE_START_O <= 1'b0;
         SLIP_O <= 1'b0;
      end else begin
         CHAIN_OUT_O <= enabled & (is_primary ? (trig_rise & (rearm_ff == 2'h0)) :
                        chain_rise);
         // secondaries start on the reference edge so capture overlaps the primary
         CAPTURE_START_O <= enabled & ref_rise;
         SLIP_O <= enabled & ~is_primary & chain_rise & ~margin_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky flags, cleared by a status read
   assign status_read = S_AXI_ARVALID_I & S_AXI_ARREADY_O & (S_AXI_ARADDR_I == `ADDR_STATUS);

   sticky_flag u_margin (
      .clk_i(CLOCK_I),
      .rst_n_i(RESET_N_I),
      .set_i(margin_hit),
      .clear_i(status_read),
      .flag_o(margin_flag)
   );

   sticky_flag u_rearm (
      .clk_i(CLOCK_I),
      .rst_n_i(RESET_N_I),
      .set_i(rearm_hit),
      .clear_i(status_read),
      .flag_o(rearm_flag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, write one to clear, set wins
   assign events = {rearm_hit, margin_hit};
   assign do_write = aw_have_ff & w_have_ff & ~S_AXI_BVALID_O;
   assign irq_clear = (do_write & (aw_addr_ff == `ADDR_IRQ_STATUS) & w_strb_ff[0]) ?
                      w_data_ff[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};

   always @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         irq_status_ff <= `IRQ_RESET;
         IRQ_O <= 1'b0;
      end else begin
         irq_status_ff <= events | (irq_status_ff & ~irq_clear);
         IRQ_O <= |(irq_status_ff & irq_mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel
   always @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         S_AXI_AWREADY_O <= 1'b0;
         S_AXI_WREADY_O <= 1'b0;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= `RESP_OKAY;
         control_ff <= `CTRL_RESET;
         irq_mask_ff <= `IRQ_RESET;
      end else begin
         S_AXI_AWREADY_O <= ~aw_have_ff & ~(S_AXI_AWVALID_I & S_AXI_AWREADY_O);
         S_AXI_WREADY_O <= ~w_have_ff & ~(S_AXI_WVALID_I & S_AXI_WREADY_O);
         if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
            aw_have_ff <= 1'b1;
            aw_addr_ff <= S_AXI_AWADDR_I;
         end
         if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
            w_have_ff <= 1'b1;
            w_data_ff <= S_AXI_WDATA_I;
            w_strb_ff <= S_AXI_WSTRB_I;
         end
         if (do_write) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= `RESP_OKAY;
            case (aw_addr_ff)
               `ADDR_CONTROL: begin
                  if (w_strb_ff[0]) begin
                     control_ff[7:0] <= w_data_ff[7:0];
                  end
               end
               `ADDR_IRQ_MASK: begin
                  if (w_strb_ff[0]) begin
                     irq_mask_ff <= w_data_ff[`IRQ_BITS-1:0];
                  end
               end
               `ADDR_IRQ_STATUS: begin
               end
               `ADDR_STATUS: begin
               end
               default: begin
                  S_AXI_BRESP_O <= `RESP_SLVERR;
               end
            endcase
         end else if (S_AXI_BVALID_O & S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   always @* begin
      rd_data = 32'h0000_0000;
      rd_ok = 1'b1;
      case (S_AXI_ARADDR_I)
         `ADDR_CONTROL: rd_data = {24'h00_0000, control_ff[7:0]};
         `ADDR_STATUS: begin
            rd_data[`ST_MARGIN] = margin_flag;
            rd_data[`ST_REARM] = rearm_flag;
            rd_data[`ST_REARM_BUSY] = (rearm_ff != 2'h0);
            rd_data[`ST_SLIPPED] = SLIP_O;
         end
         `ADDR_IRQ_STATUS: rd_data = {30'h0000_0000, irq_status_ff};
         `ADDR_IRQ_MASK: rd_data = {30'h0000_0000, irq_mask_ff};
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h0000_0000;
         S_AXI_RRESP_O <= `RESP_OKAY;
      end else if (S_AXI_ARVALID_I & S_AXI_ARREADY_O) begin
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RDATA_O <= rd_data;
         S_AXI_RRESP_O <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_RVALID_O) begin
         if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_ARREADY_O <= 1'b1;
         end
      end else begin
         S_AXI_ARREADY_O <= 1'b1;
      end
   end
endmodule

/* File: hw/sticky_flag.v */
// sticky event flag: set wins over clear
`timescale 1ns/100ps
module sticky_flag (
   input wire clk_i,
   input wire rst_n_i,
   input wire set_i,
   input wire clear_i,
   output reg flag_o
);
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clear_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule

/* File: shared/chain_monitor_consts.vh */
// constants for the chain trigger monitor: register map, fields, timing
`ifndef CHAIN_MONITOR_CONSTS_VH
`define CHAIN_MONITOR_CONSTS_VH

`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_IRQ_STATUS 4'h8
`define ADDR_IRQ_MASK 4'hc

`define CTRL_PRIMARY 0
`define CTRL_ENABLE 1
`define CTRL_WIN_LO 2
`define CTRL_WIN_HI 5
`define CTRL_RESET 32'h0000_0000
`define WIN_WIDTH 4

`define ST_MARGIN 0
`define ST_REARM 1
`define ST_REARM_BUSY 2
`define ST_SLIPPED 3

`define IRQ_BITS 2
`define IRQ_RESET 2'h0

`define REARM_REF_CYCLES 2'h2
`define REF_CNT_WIDTH 16

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: testbench/chain_neighbour_model.sv */
// upstream unit: shared reference clock and a chain edge at a set delay
`timescale 1ns/100ps
module chain_neighbour_model #(
   parameter HALF = 8
) (
   input wire clk_i,
   input wire send_i,
   input wire [7:0] delay_i,
   output reg ref_o,
   output reg chain_o
);
reg [7:0] cnt_ff = 8'h00;
reg armed_ff = 1'b0;
reg [2:0] hold_ff = 3'h0;
initial ref_o = 1'b0;
initial chain_o = 1'b0;
always @(posedge clk_i) begin
   cnt_ff <= (cnt_ff == 2 * HALF - 1) ? 8'h00 : cnt_ff + 8'h01;
   ref_o <= cnt_ff >= HALF - 1 && cnt_ff != 2 * HALF - 1;
   chain_o <= hold_ff > 3'h1;
   if (send_i)
      armed_ff <= 1'b1;
   // chain edge lags the ref edge by the configured delay, as offsets and spans are set upstream
   if (armed_ff && cnt_ff == HALF - 1 + delay_i) begin
      armed_ff <= 1'b0;
      hold_ff <= 3'h4;
      chain_o <= 1'b1;
   end else if (hold_ff != 3'h0)
      hold_ff <= hold_ff - 3'h1;
end
endmodule

/* File: testbench/chain_port_monitor.sv */
// port checker for the chain trigger monitor
`timescale 1ns/100ps
`include "chain_monitor_consts.vh"
module chain_port_checker (
   input wire logic CLOCK_I,
   input wire logic RESET_N_I,
   input wire logic CHAIN_OUT_O,
   input wire logic SLIP_O,
   input wire logic CAPTURE_START_O,
   input wire logic IRQ_O,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [3:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [1:0] S_AXI_RRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I
);
default clocking @(posedge CLOCK_I); endclocking
default disable iff (!RESET_N_I);
sequence s_ar_taken;
   S_AXI_ARVALID_I && S_AXI_ARREADY_O;
endsequence
sequence s_ar_bad;
   s_ar_taken ##0 S_AXI_ARADDR_I[1:0] != 2'h0;
endsequence
a_reset_quiet: assert property (disable iff (1'b0) !RESET_N_I |=>
   !IRQ_O && !CHAIN_OUT_O && !SLIP_O) else $error("output active after reset");
a_chain_single: assert property (CHAIN_OUT_O |=> !CHAIN_OUT_O)
   else $error("chain pulse too long");
a_slip_single: assert property (SLIP_O |=> !SLIP_O)
   else $error("slip pulse too long");
a_capture_single: assert property (CAPTURE_START_O |=> !CAPTURE_START_O)
   else $error("capture pulse too long");
a_read_answer: assert property (s_ar_taken |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
   else $error("read not answered");
a_read_done: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=>
   !S_AXI_RVALID_O && S_AXI_ARREADY_O) else $error("read not closed");
a_read_refuse: assert property (s_ar_bad |=>
   S_AXI_RRESP_O == `RESP_SLVERR && S_AXI_RDATA_O == 32'h0) else $error("bad read accepted");
a_write_done: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
   else $error("write response stuck");
endmodule
bind chain_trigger_monitor chain_port_checker i_chain_port_checker (
   .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .CHAIN_OUT_O(CHAIN_OUT_O), .SLIP_O(SLIP_O),
   .CAPTURE_START_O(CAPTURE_START_O), .IRQ_O(IRQ_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
   .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
   .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
   .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
   .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I));

/* File: testbench/chain_trigger_monitor_test.sv */
// self-checking bench for the chain trigger monitor
`timescale 1ns/100ps
`include "chain_monitor_consts.vh"
module chain_trigger_monitor_test;
logic clk = 0, rst_n = 0, trig = 0, send = 0, awvalid = 0, wvalid = 0, bready = 0;
logic arvalid = 0, rready = 0, warn;
logic [3:0] win = 0, awaddr = 0, araddr = 0, w;
logic [7:0] dly = 0;
logic [31:0] wdata = 0, rdv;
logic [15:0] tab [6] = '{16'h1203, 16'h1204, 16'h1200, 16'h0265, 16'h0225, 16'h1201};
wire ref_clk, chain_in, chain_out, irq, slip, awready, wready, bvalid, arready, rvalid;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
integer err_count = 0, checked = 0, fwd = 0, slips = 0, i, f, s;
always #5 clk = ~clk;
always @(posedge clk) begin
   fwd = fwd + (chain_out === 1'b1);
   slips = slips + (slip === 1'b1);
end
chain_neighbour_model i_chain_neighbour_model (.clk_i(clk), .send_i(send), .delay_i(dly),
   .ref_o(ref_clk), .chain_o(chain_in));
chain_trigger_monitor i_chain_trigger_monitor (.CLOCK_I(clk), .RESET_N_I(rst_n),
   .REF_CLK_I(ref_clk), .CHAIN_IN_I(chain_in), .TRIGGER_I(trig), .RATE_WINDOW_I(win),
   .CHAIN_OUT_O(chain_out), .CAPTURE_START_O(), .SLIP_O(slip), .IRQ_O(irq),
   .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
   .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
   .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
   .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
   .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
   .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
task chk(input string nm, input [31:0] e, input [31:0] g);
   begin
      checked = checked + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   end
endtask
////////////////////////////////////////////////////////////////
task wr(input [3:0] a, input [31:0] d, input [2:0] er);
   integer n;
   begin
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge clk);
         n = n + 1;
         if (awready === 1'b1)
            awvalid <= 0;
         if (wready === 1'b1)
            wvalid <= 0;
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 0;
      chk("write response", er, {bvalid, bresp});
   end
endtask
task rdchk(input string nm, input [3:0] a, input [31:0] e, input [31:0] m, input [2:0] er);
   integer n;
   begin
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge clk);
         n = n + 1;
         if (arready === 1'b1)
            arvalid <= 0;
      end while (rvalid !== 1'b1 && n < 50);
      rdv = rdata;
      rready <= 0;
      chk("read response", er, {rvalid, rresp});
      chk(nm, e, rdv & m);
   end
endtask
task pulse(input integer gap);
   begin
      @(posedge clk);
      trig <= 1;
      repeat (3) @(posedge clk);
      trig <= 0;
      repeat (gap) @(posedge clk);
   end
endtask
task finish_test;
   begin
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
endtask
////////////////////////////////////////////////////////////////
initial begin
   repeat (20000) @(posedge clk);
   err_count = err_count + 1;
   finish_test;
end
initial begin
   repeat (8) @(posedge clk);
   rst_n <= 1;
   rdchk("control", `ADDR_CONTROL, 0, 32'hffffffff, 3'h4);
   rdchk("status", `ADDR_STATUS, 0, 32'h3, 3'h4);
   rdchk("unmapped", 4'h6, 0, 32'hffffffff, 3'h6);
   wr(4'h6, 32'h3, 3'h6);
   wr(`ADDR_IRQ_MASK, 32'h3, 3'h4);
   for (i = 0; i < 6; i = i + 1) begin
      if (i == 5)
         wr(`ADDR_IRQ_MASK, 32'h0, 3'h4);
      win <= tab[i][7:4];
      dly <= {4'h0, tab[i][3:0]};
      wr(`ADDR_CONTROL, {24'h0, tab[i][15:8]}, 3'h4);
      w = tab[i][13:10] != 0 ? tab[i][13:10] : tab[i][7:4];
      // the chain edge counts inside the window up to and including w cycles after the ref edge
      warn = tab[i][3:0] <= w;
      f = fwd;
      s = slips;
      @(posedge clk);
      send <= 1;
      @(posedge clk);
      send <= 0;
      repeat (60) @(posedge clk);
      chk("forwarded", f + 1, fwd);
      chk("slip", s + !warn, slips);
      chk("irq", warn && i < 5, irq);
      rdchk("warn", `ADDR_STATUS, warn, 32'h3, 3'h4);
      rdchk("warn cleared", `ADDR_STATUS, 0, 32'h3, 3'h4);
      rdchk("irq status", `ADDR_IRQ_STATUS, warn, 32'h3, 3'h4);
      wr(`ADDR_IRQ_STATUS, 32'h1, 3'h4);
      // the interrupt output follows the status one cycle later
      @(posedge clk);
      chk("irq cleared", 0, irq);
   end
   wr(`ADDR_IRQ_MASK, 32'h3, 3'h4);
   wr(`ADDR_CONTROL, 32'h3, 3'h4);
   rdchk("control", `ADDR_CONTROL, 32'h3, 32'hffffffff, 3'h4);
   f = fwd;
   pulse(3);
   pulse(60);
   chk("refused trigger", f + 1, fwd);
   chk("irq rearm", 1, irq);
   rdchk("rearm", `ADDR_STATUS, 32'h2, 32'h3, 3'h4);
   pulse(40);
   pulse(60);
   chk("rearm over", f + 3, fwd);
   rdchk("no rearm", `ADDR_STATUS, 0, 32'h3, 3'h4);
   pulse(3);
   pulse(20);
   rst_n <= 0;
   repeat (2) @(posedge clk);
   rst_n <= 1;
   rdchk("after reset", `ADDR_STATUS, 0, 32'h3, 3'h4);
   chk("irq after reset", 0, irq);
   finish_test;
end
endmodule
